// ### hdl/seti_map.vh
// register offsets, field positions and reset values of the event threshold block
`ifndef SETI_MAP_VH
`define SETI_MAP_VH

// ----------------------------------------
// register offsets (i2c register pointer)
// ----------------------------------------
`define SETI_PUL_LO 8'h02
`define SETI_PUL_HI 8'h03
`define SETI_PML_LO 8'h04
`define SETI_PML_HI 8'h05
`define SETI_PLL_LO 8'h06
`define SETI_PLL_HI 8'h07
`define SETI_TUL 8'h08
`define SETI_TML 8'h09
`define SETI_TLL 8'h0a
`define SETI_EN 8'h0b
`define SETI_CFG 8'h0c
`define SETI_SRC 8'h0d

// ----------------------------------------
// event bit positions (enable, routing and source share them)
// ----------------------------------------
`define SETI_B_TEMPERATURE_WINDOW_EVENT 0
`define SETI_B_PRESSURE_WINDOW_EVENT 1
`define SETI_B_TEMPERATURE_TRAVERSAL_EVENT 2
`define SETI_B_PRESSURE_TRAVERSAL_EVENT 3
`define SETI_B_T_RDY 4
`define SETI_B_PRESSURE_READY_EVENT 5
`define SETI_B_MODE 6
`define SETI_B_DEVICE_READY_STATUS 6
`define SETI_B_THRESHOLD_ERROR_FLAG 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define SETI_RST_BYTE 8'h00
`define SETI_RST_WORD 16'h0000

// ----------------------------------------
// bus address: upper six bits fixed, lowest bit is the inverted select pin
// ----------------------------------------
`define SETI_ADDR_HI 6'h3b

`endif

// ### hdl/seti_core.v
// event detection, threshold registers and i2c register access of the sensor
`timescale 1ns/10ps
`include "seti_map.vh"
// How it works
// - pressure limit: unsigned 16-bit, 0.02 mbar steps
// - select=1: pressure-channel limits signed meters
// - middle, lower pressure limits: same 16-bit format
// - three temperature limits, 8-bit signed Celsius
// - inconsistent limits set threshold error flag
// - pressure done raises pressure ready event
// - temperature done raises temperature ready event
// - pressure crossing middle limit raises traversal
// - temperature crossing middle limit raises traversal
// - pressure outside lower..upper raises window event
// - temperature outside lower..upper raises window event
// - six events active high, sticky until cleared
// - read or convert command clears events
// - enable register: one bit per event
// - routing register selects events for irq pin
// - routing register bit selects pressure or altitude
// - source register read-only: flags plus ready
// - ready only asleep and not busy
// - enabled unrouted event flags but drives no pin
module seti_core (
  // clock and reset
  input wire clk,
  input wire nrst,
  // i2c pins and address select strap
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire addr_sel_in,
  // measurement results from the conversion engine
  input wire pa_done,
  input wire [15:0] pa_value,
  input wire t_done,
  input wire [7:0] t_value,
  // command decode and power state of the device
  input wire clr_pa,
  input wire clr_t,
  input wire core_sleep,
  input wire core_busy,
  // routed interrupt pin
  output reg routed_irq_pin
);

  // ----------------------------------------
  // states of the i2c slave
  // ----------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_PTR = 3'd2;
  localparam ST_WR = 3'd3;
  localparam ST_RD = 3'd4;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [15:0] pressure_upper_limit;
  reg [15:0] pressure_middle_limit;
  reg [15:0] pressure_lower_limit;
  reg [7:0] temperature_upper_limit;
  reg [7:0] temperature_middle_limit;
  reg [7:0] temperature_lower_limit;
  reg [7:0] event_enable_mask;
  reg [7:0] event_routing_config;
  reg [5:0] event_flags;
  reg threshold_error_flag;
  reg device_ready_status;

  wire pressure_altitude_select;
  assign pressure_altitude_select = event_routing_config[`SETI_B_MODE];

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg [1:0] sel_sync;
  reg scl_prev;
  reg sda_prev;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sel_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      sel_sync <= {sel_sync[0], addr_sel_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire [6:0] my_addr;
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;
  assign bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
  assign bus_stop = scl_s & scl_prev & ~sda_prev & sda_s;
  // select pin tied high picks the even address
  assign my_addr = {`SETI_ADDR_HI, ~sel_sync[1]};

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  function [7:0] rd_mux;
    input [7:0] ptr;
    begin
      case (ptr)
        `SETI_PUL_LO: rd_mux = pressure_upper_limit[7:0];
        `SETI_PUL_HI: rd_mux = pressure_upper_limit[15:8];
        `SETI_PML_LO: rd_mux = pressure_middle_limit[7:0];
        `SETI_PML_HI: rd_mux = pressure_middle_limit[15:8];
        `SETI_PLL_LO: rd_mux = pressure_lower_limit[7:0];
        `SETI_PLL_HI: rd_mux = pressure_lower_limit[15:8];
        `SETI_TUL: rd_mux = temperature_upper_limit;
        `SETI_TML: rd_mux = temperature_middle_limit;
        `SETI_TLL: rd_mux = temperature_lower_limit;
        `SETI_EN: rd_mux = event_enable_mask & 8'h3f;
        `SETI_CFG: rd_mux = event_routing_config & 8'h7f;
        `SETI_SRC: rd_mux = {threshold_error_flag, device_ready_status, event_flags};
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // i2c slave: sample on scl rise, drive on scl fall
  // ----------------------------------------
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] shift_out;
  reg [7:0] reg_ptr;
  reg ack_phase;
  reg wr_stb;
  reg [7:0] wr_ptr;
  reg [7:0] wr_data;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      reg_ptr <= 8'h00;
      ack_phase <= 1'b0;
      wr_stb <= 1'b0;
      wr_ptr <= 8'h00;
      wr_data <= 8'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state <= ST_IDLE;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
      end else if (state != ST_IDLE && scl_rise) begin
        if (!ack_phase) begin
          shift_in <= {shift_in[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == ST_RD && sda_s) begin
          // master answered not-ack: stop sending
          state <= ST_IDLE;
        end
      end else if (state != ST_IDLE && scl_fall) begin
        if (ack_phase) begin
          ack_phase <= 1'b0;
          bit_cnt <= 4'h0;
          sda_oe <= (state == ST_RD) ? ~shift_out[7] : 1'b0;
        end else if (bit_cnt == 4'h8) begin
          case (state)
            ST_ADDR: begin
              if (shift_in[7:1] == my_addr) begin
                ack_phase <= 1'b1;
                sda_oe <= 1'b1;
                state <= shift_in[0] ? ST_RD : ST_PTR;
                shift_out <= rd_mux(reg_ptr);
              end else begin
                state <= ST_IDLE;
              end
            end
            ST_PTR: begin
              reg_ptr <= shift_in;
              ack_phase <= 1'b1;
              sda_oe <= 1'b1;
              state <= ST_WR;
            end
            ST_WR: begin
              wr_stb <= 1'b1;
              wr_ptr <= reg_ptr;
              wr_data <= shift_in;
              reg_ptr <= reg_ptr + 8'h01;
              ack_phase <= 1'b1;
              sda_oe <= 1'b1;
            end
            ST_RD: begin
              // release for the master's ack, preload the next byte
              ack_phase <= 1'b1;
              sda_oe <= 1'b0;
              reg_ptr <= reg_ptr + 8'h01;
              shift_out <= rd_mux(reg_ptr + 8'h01);
            end
            default: state <= ST_IDLE;
          endcase
        end else if (state == ST_RD) begin
          shift_out <= {shift_out[6:0], 1'b0};
          sda_oe <= ~shift_out[6];
        end
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pressure_upper_limit <= `SETI_RST_WORD;
      pressure_middle_limit <= `SETI_RST_WORD;
      pressure_lower_limit <= `SETI_RST_WORD;
      temperature_upper_limit <= `SETI_RST_BYTE;
      temperature_middle_limit <= `SETI_RST_BYTE;
      temperature_lower_limit <= `SETI_RST_BYTE;
      event_enable_mask <= `SETI_RST_BYTE;
      event_routing_config <= `SETI_RST_BYTE;
    end else if (wr_stb) begin
      case (wr_ptr)
        `SETI_PUL_LO: pressure_upper_limit[7:0] <= wr_data;
        `SETI_PUL_HI: pressure_upper_limit[15:8] <= wr_data;
        `SETI_PML_LO: pressure_middle_limit[7:0] <= wr_data;
        `SETI_PML_HI: pressure_middle_limit[15:8] <= wr_data;
        `SETI_PLL_LO: pressure_lower_limit[7:0] <= wr_data;
        `SETI_PLL_HI: pressure_lower_limit[15:8] <= wr_data;
        `SETI_TUL: temperature_upper_limit <= wr_data;
        `SETI_TML: temperature_middle_limit <= wr_data;
        `SETI_TLL: temperature_lower_limit <= wr_data;
        `SETI_EN: event_enable_mask <= wr_data & 8'h3f;
        `SETI_CFG: event_routing_config <= wr_data & 8'h7f;
        default: event_routing_config <= event_routing_config;
      endcase
    end
  end

  // ----------------------------------------
  // comparisons
  // ----------------------------------------
  function lt16;
    input [15:0] a;
    input [15:0] b;
    input sgn;
    begin
      lt16 = sgn ? ($signed(a) < $signed(b)) : (a < b);
    end
  endfunction

  reg [15:0] pa_prev;
  reg pa_prev_ok;
  reg [7:0] t_prev;
  reg t_prev_ok;

  wire pa_below_mid_now;
  wire pa_below_mid_prev;
  wire t_below_mid_now;
  wire t_below_mid_prev;
  wire pa_cross;
  wire t_cross;
  wire pa_out;
  wire t_out;
  wire limit_bad;
  assign pa_below_mid_now = lt16(pa_value, pressure_middle_limit, pressure_altitude_select);
  assign pa_below_mid_prev = lt16(pa_prev, pressure_middle_limit, pressure_altitude_select);
  assign t_below_mid_now = $signed(t_value) < $signed(temperature_middle_limit);
  assign t_below_mid_prev = $signed(t_prev) < $signed(temperature_middle_limit);
  assign pa_cross = pa_prev_ok & (pa_below_mid_now ^ pa_below_mid_prev);
  assign t_cross = t_prev_ok & (t_below_mid_now ^ t_below_mid_prev);
  assign pa_out = lt16(pa_value, pressure_lower_limit, pressure_altitude_select)
                | lt16(pressure_upper_limit, pa_value, pressure_altitude_select);
  assign t_out = ($signed(t_value) < $signed(temperature_lower_limit))
               | ($signed(temperature_upper_limit) < $signed(t_value));
  // a middle limit outside the window is treated as inconsistent as well
  assign limit_bad = lt16(pressure_upper_limit, pressure_lower_limit, pressure_altitude_select)
                   | lt16(pressure_middle_limit, pressure_lower_limit, pressure_altitude_select)
                   | lt16(pressure_upper_limit, pressure_middle_limit, pressure_altitude_select)
                   | ($signed(temperature_upper_limit) < $signed(temperature_lower_limit))
                   | ($signed(temperature_middle_limit) < $signed(temperature_lower_limit))
                   | ($signed(temperature_upper_limit) < $signed(temperature_middle_limit));

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pa_prev <= `SETI_RST_WORD;
      pa_prev_ok <= 1'b0;
      t_prev <= `SETI_RST_BYTE;
      t_prev_ok <= 1'b0;
    end else begin
      if (pa_done) begin
        pa_prev <= pa_value;
        pa_prev_ok <= 1'b1;
      end
      if (t_done) begin
        t_prev <= t_value;
        t_prev_ok <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  reg [5:0] ev_raw;
  reg [5:0] ev_clr;
  wire [5:0] ev_gate;
  always @* begin
    ev_raw = 6'h00;
    ev_raw[`SETI_B_PRESSURE_READY_EVENT] = pa_done;
    ev_raw[`SETI_B_T_RDY] = t_done;
    ev_raw[`SETI_B_PRESSURE_TRAVERSAL_EVENT] = pa_done & pa_cross;
    ev_raw[`SETI_B_TEMPERATURE_TRAVERSAL_EVENT] = t_done & t_cross;
    ev_raw[`SETI_B_PRESSURE_WINDOW_EVENT] = pa_done & pa_out;
    ev_raw[`SETI_B_TEMPERATURE_WINDOW_EVENT] = t_done & t_out;
    ev_clr = 6'h00;
    ev_clr[`SETI_B_PRESSURE_READY_EVENT] = clr_pa;
    ev_clr[`SETI_B_PRESSURE_TRAVERSAL_EVENT] = clr_pa;
    ev_clr[`SETI_B_PRESSURE_WINDOW_EVENT] = clr_pa;
    ev_clr[`SETI_B_T_RDY] = clr_t;
    ev_clr[`SETI_B_TEMPERATURE_TRAVERSAL_EVENT] = clr_t;
    ev_clr[`SETI_B_TEMPERATURE_WINDOW_EVENT] = clr_t;
  end

  // traversal and window only count when their ready event is enabled too
  assign ev_gate = event_enable_mask[5:0] & {2'b11,
                   {2{event_enable_mask[`SETI_B_PRESSURE_READY_EVENT]}} & 2'b10 | {2{event_enable_mask[`SETI_B_T_RDY]}} & 2'b01,
                   {2{event_enable_mask[`SETI_B_PRESSURE_READY_EVENT]}} & 2'b10 | {2{event_enable_mask[`SETI_B_T_RDY]}} & 2'b01};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          event_flags[gi] <= 1'b0;
        end else if (ev_raw[gi] & ev_gate[gi]) begin
          event_flags[gi] <= 1'b1;
        end else if (ev_clr[gi]) begin
          event_flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // status and pin
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      threshold_error_flag <= 1'b0;
      device_ready_status <= 1'b0;
      routed_irq_pin <= 1'b0;
    end else begin
      threshold_error_flag <= limit_bad;
      device_ready_status <= core_sleep & ~core_busy;
      routed_irq_pin <= |(event_flags & event_routing_config[5:0]);
    end
  end

endmodule // seti_core

// ### test/seti_core_props.sv
// pin-level assertions for the event threshold block
`timescale 1ns/10ps
module seti_core_props (
  // clock and reset
  input wire clk,
  input wire nrst,
  // i2c pins and strap
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire addr_sel_in,
  // results and commands
  input wire pa_done,
  input wire [15:0] pa_value,
  input wire t_done,
  input wire [7:0] t_value,
  input wire clr_pa,
  input wire clr_t,
  input wire core_sleep,
  input wire core_busy,
  // interrupt pin
  input wire routed_irq_pin
);
  reg seen_done;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // helper: any result seen since reset
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_done <= 1'b0;
    end else if (pa_done || t_done) begin
      seen_done <= 1'b1;
    end
  end
  // a register write can also move the pin, and it always lands while the ack is held
  AST_IRQ_RISE: assert property ($rose(routed_irq_pin) |-> $past(pa_done, 2) || $past(t_done, 2) || sda_oe)
    else $error("irq rose without a result");
  AST_IRQ_FALL: assert property ($fell(routed_irq_pin) |-> $past(clr_pa, 2) || $past(clr_t, 2) || $past(clr_pa, 3)
    || $past(clr_t, 3) || sda_oe || $past(sda_oe)) else $error("irq fell without a clear");
  AST_IRQ_QUIET: assert property (!seen_done |-> !routed_irq_pin)
    else $error("irq high before any result");
  AST_RST_QUIET: assert property ($rose(nrst) |-> !routed_irq_pin && !sda_oe)
    else $error("outputs active at reset release");
  AST_OE_START: assert property ($rose(nrst) |-> !sda_oe [*8])
    else $error("sda driven before any frame");
  AST_OD_LOW: assert property (!sda_out)
    else $error("sda driven high");
  AST_OE_STANDS: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("sda pull too short");
  AST_OE_SCL_HIGH: assert property (scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe))
    else $error("sda changed while scl high");
endmodule // seti_core_props
bind seti_core seti_core_props chk (.clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .addr_sel_in(addr_sel_in), .pa_done(pa_done), .pa_value(pa_value), .t_done(t_done),
  .t_value(t_value), .clr_pa(clr_pa), .clr_t(clr_t), .core_sleep(core_sleep), .core_busy(core_busy),
  .routed_irq_pin(routed_irq_pin));

// ### test/seti_host.sv
// i2c host model that programs and reads the block
`timescale 1ns/10ps
module seti_host (
  // clock
  input wire clk,
  // i2c wires
  input wire sda,
  output reg scl,
  output reg sda_pull
);
  // scl stands high between frames; one bit is 8 clk cycles
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task q;
    repeat (2) @(negedge clk);
  endtask
  task bitx(input b, output r);
    begin
      q;
      sda_pull = !b;
      q;
      scl = 1'b1;
      q;
      r = sda;
      q;
      scl = 1'b0;
    end
  endtask
  task start;
    begin
      q;
      sda_pull = 1'b0;
      q;
      scl = 1'b1;
      q;
      sda_pull = 1'b1;
      q;
      scl = 1'b0;
    end
  endtask
  task stop;
    begin
      q;
      sda_pull = 1'b1;
      q;
      scl = 1'b1;
      q;
      sda_pull = 1'b0;
      q;
    end
  endtask
  // m high releases the ninth bit: ack wait on writes, nack on the last read
  task xbyte(input [7:0] d, input m, output [7:0] r, output a);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitx(d[i], s);
        r[i] = s;
      end
      bitx(m, s);
      a = !s;
    end
  endtask
  task wr(input [6:0] ad, input [7:0] p, input [7:0] d, output ok);
    reg [7:0] r;
    reg a1, a2, a3;
    begin
      start;
      xbyte({ad, 1'b0}, 1'b1, r, a1);
      xbyte(p, 1'b1, r, a2);
      xbyte(d, 1'b1, r, a3);
      stop;
      ok = a1 & a2 & a3;
    end
  endtask
  task rd(input [6:0] ad, input [7:0] p, output [7:0] d, output ok);
    reg [7:0] r;
    reg a1, a2, a3, a4;
    begin
      start;
      xbyte({ad, 1'b0}, 1'b1, r, a1);
      xbyte(p, 1'b1, r, a2);
      start;
      xbyte({ad, 1'b1}, 1'b1, r, a3);
      xbyte(8'hff, 1'b1, d, a4);
      stop;
      ok = a1 & a2 & a3;
    end
  endtask
endmodule // seti_host

// ### test/seti_core_tb_top.sv
// self-checking bench for the event threshold block
`timescale 1ns/10ps
`include "seti_map.vh"
module seti_core_tb_top;
  reg clk, nrst, addr_sel_in, pa_done, t_done, clr_pa, clr_t, core_sleep, core_busy, ok;
  reg [15:0] pa_value;
  reg [7:0] t_value, rv;
  reg [23:0] rows [0:12];
  wire scl, host_pull, sda_out, sda_oe, routed_irq_pin;
  wire sda_line = !(host_pull || sda_oe);
  integer errors, n_tests, i;
  seti_core dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel_in(addr_sel_in), .pa_done(pa_done), .pa_value(pa_value), .t_done(t_done), .t_value(t_value),
    .clr_pa(clr_pa), .clr_t(clr_t), .core_sleep(core_sleep), .core_busy(core_busy), .routed_irq_pin(routed_irq_pin));
  seti_host host (.clk(clk), .sda(sda_line), .scl(scl), .sda_pull(host_pull));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task w(input [7:0] p, input [7:0] d);
    begin
      host.wr(7'h77, p, d, ok);
      chk("ack", 8'h01, {7'h00, ok});
    end
  endtask
  task r(input [7:0] p, input [7:0] e);
    begin
      host.rd(7'h77, p, rv, ok);
      chk("register", e, rv);
    end
  endtask
  // one result or clear pulse; flags settle one edge later, the pin two edges later
  task ev(input pa, input tt, input [15:0] v, input cp, input ct);
    begin
      @(negedge clk);
      {pa_done, t_done, clr_pa, clr_t} = {pa, tt, cp, ct};
      {pa_value, t_value} = {v, v[7:0]};
      @(negedge clk);
      {pa_done, t_done, clr_pa, clr_t} = 4'h0;
      repeat (2) @(negedge clk);
    end
  endtask
  task irq(input e);
    chk("irq", {7'h00, e}, {7'h00, routed_irq_pin});
  endtask
  task summarize;
    begin
      if (errors == 0 && n_tests > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #9000000;
    errors = errors + 1;
    summarize;
  end
  initial begin
    {nrst, addr_sel_in, pa_done, t_done, clr_pa, clr_t, core_busy} = 7'h00;
    {core_sleep, pa_value, t_value, errors, n_tests} = 0;
    core_sleep = 1'b1;
    {rows[0], rows[1], rows[2], rows[3]} = {24'h02a5a5, 24'h035a5a, 24'h04c3c3, 24'h053c3c};
    {rows[4], rows[5], rows[6], rows[7]} = {24'h060f0f, 24'h07f0f0, 24'h082d2d, 24'h091414};
    {rows[8], rows[9], rows[10], rows[11], rows[12]} = {24'h0aecec, 24'h0bff3f, 24'h0cff7f, 24'h0dff40, 24'h0fff00};
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 2; i < 13; i = i + 1) r(i[7:0], 8'h00);
    r(`SETI_SRC, 8'h40);
    for (i = 0; i < 13; i = i + 1) begin
      w(rows[i][23:16], rows[i][15:8]);
      r(rows[i][23:16], rows[i][7:0]);
    end
    // limits 0x5aa5/0x3cc3/0xf00f only hold together when read as signed
    w(`SETI_CFG, 8'h3f);
    r(`SETI_SRC, 8'hc0);
    w(`SETI_CFG, 8'h7f);
    r(`SETI_SRC, 8'h40);
    ev(1, 0, 16'h4000, 0, 0);
    irq(1'b1);
    r(`SETI_SRC, 8'h60);
    ev(1, 0, 16'hf000, 0, 0);
    r(`SETI_SRC, 8'h6a);
    ev(0, 1, 16'h000a, 0, 0);
    ev(0, 1, 16'h001e, 0, 0);
    ev(0, 1, 16'h0032, 0, 0);
    r(`SETI_SRC, 8'h7f);
    ev(0, 0, 16'h0000, 0, 1);
    r(`SETI_SRC, 8'h6a);
    ev(0, 0, 16'h0000, 1, 0);
    irq(1'b0);
    ev(1, 0, 16'h4000, 1, 0);
    r(`SETI_SRC, 8'h68);
    ev(0, 0, 16'h0000, 1, 0);
    w(`SETI_TLL, 8'h30);
    r(`SETI_SRC, 8'hc0);
    w(`SETI_TLL, 8'hec);
    w(`SETI_CFG, 8'h40);
    ev(0, 1, 16'h00e2, 0, 0);
    irq(1'b0);
    r(`SETI_SRC, 8'h55);
    ev(0, 0, 16'h0000, 0, 1);
    w(`SETI_EN, 8'h04);
    ev(0, 1, 16'h001e, 0, 0);
    r(`SETI_SRC, 8'h40);
    w(`SETI_EN, 8'h10);
    ev(0, 1, 16'h000a, 0, 0);
    r(`SETI_SRC, 8'h50);
    ev(0, 0, 16'h0000, 0, 1);
    core_busy = 1'b1;
    r(`SETI_SRC, 8'h00);
    {core_busy, core_sleep} = 2'b00;
    r(`SETI_SRC, 8'h00);
    core_sleep = 1'b1;
    r(`SETI_SRC, 8'h40);
    host.wr(7'h76, `SETI_EN, 8'h3f, ok);
    chk("nack", 8'h00, {7'h00, ok});
    r(`SETI_EN, 8'h10);
    // strap high moves the device to the even address
    addr_sel_in = 1'b1;
    host.rd(7'h76, `SETI_EN, rv, ok);
    chk("strap ack", 8'h01, {7'h00, ok});
    chk("strap read", 8'h10, rv);
    addr_sel_in = 1'b0;
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    r(`SETI_CFG, 8'h00);
    summarize;
  end
endmodule // seti_core_tb_top
